/* hdl/uar_pkg.sv */
// shared constants and types for the usb address and request registers
package uar_pkg;
  localparam int          ADDR_W        = 7;
  localparam int          UFRM_W        = 3;
  localparam logic [7:0]  OFF_BUS_ADDR  = 8'h50;
  localparam logic [7:0]  OFF_REQ_TYPE  = 8'h54;
  localparam logic [7:0]  OFF_UFRM      = 8'h70;
  localparam logic [7:0]  OFF_CTRL      = 8'h74;
  localparam int          CTRL_HOST_BIT = 0;
  localparam int          CTRL_TRIG_BIT = 1;
  localparam logic [15:0] REQ_RST       = 16'h0000;
  localparam logic [1:0]  RESP_OKAY     = 2'b00;
  localparam logic [1:0]  RESP_SLVERR   = 2'b10;

  // events and levels from the usb link logic
  typedef struct packed {
    logic              firstPortHs;
    logic              secondPortHs;
    logic [UFRM_W-1:0] microframe;
    logic              setAddrDone;
    logic [ADDR_W-1:0] setAddrValue;
    logic              busReset;
    logic              setupValid;
    logic [15:0]       setupReq;
    logic              txDone;
  } uar_link_t;

  // state handed to the usb link logic
  typedef struct packed {
    logic              hostMode;
    logic              setupTransmitTrigger;
    logic [ADDR_W-1:0] assignedBusAddress;
    logic [15:0]       setupRequestType;
  } uar_ctl_t;
endpackage

/* hdl/uar_ufrm.sv */
// microframe count field, forced to zero without a high-speed port
`timescale 1ns/1ps
module uar_ufrm
  import uar_pkg::*;
#(
  parameter int W = UFRM_W
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         arst_n,
  // link side
  input  wire logic         firstPortHs,
  input  wire logic         secondPortHs,
  input  wire logic [W-1:0] microframe,
  // register view
  output logic      [W-1:0] microframeCountField_r
);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      microframeCountField_r <= '0;
    end else if (firstPortHs || secondPortHs) begin
      microframeCountField_r <= microframe;
    end else begin
      microframeCountField_r <= '0;
    end
  end

  a_ufrm_follow: assert property (@(posedge clk) disable iff (!arst_n)
    (firstPortHs || secondPortHs) |=> microframeCountField_r == $past(microframe))
    else $error("microframe field did not follow the count");
  a_ufrm_zero: assert property (@(posedge clk) disable iff (!arst_n)
    !(firstPortHs || secondPortHs) |=> microframeCountField_r == '0)
    else $error("microframe field not zero without high speed");
endmodule

/* hdl/uar_addr.sv */
// assigned bus address held for peripheral mode
`timescale 1ns/1ps
module uar_addr
  import uar_pkg::*;
#(
  parameter int W = ADDR_W
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         arst_n,
  // mode and link events
  input  wire logic         hostMode,
  input  wire logic         setAddrDone,
  input  wire logic [W-1:0] setAddrValue,
  input  wire logic         busReset,
  // register view
  output logic      [W-1:0] assignedBusAddress_r
);
  // bus reset outranks a set-address completion in the same cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      assignedBusAddress_r <= '0;
    end else if (!hostMode) begin
      if (busReset) begin
        assignedBusAddress_r <= '0;
      end else if (setAddrDone) begin
        assignedBusAddress_r <= setAddrValue;
      end
    end
  end

  sequence s_periph_set;
    !hostMode && setAddrDone && !busReset;
  endsequence

  a_addr_load: assert property (@(posedge clk) disable iff (!arst_n)
    s_periph_set |=> assignedBusAddress_r == $past(setAddrValue))
    else $error("address not loaded on set address");
  a_addr_busreset: assert property (@(posedge clk) disable iff (!arst_n)
    (!hostMode && busReset) |=> assignedBusAddress_r == '0)
    else $error("address not cleared by bus reset");
  a_addr_hold: assert property (@(posedge clk) disable iff (!arst_n)
    (hostMode || !(setAddrDone || busReset)) |=> $stable(assignedBusAddress_r))
    else $error("address changed without cause");
endmodule

/* hdl/uar_regs.sv */
// usb address and setup request registers behind an axi4-lite slave
`timescale 1ns/1ps
module uar_regs
  import uar_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // axi4-lite write address
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  // axi4-lite write data
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // axi4-lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // axi4-lite read address
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  // axi4-lite read data
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // usb link logic
  input  wire uar_link_t   linkIn,
  output uar_ctl_t         ctlOut
);
  logic              awReady_r;
  logic              wReady_r;
  logic              bValid_r;
  logic [1:0]        bResp_r;
  logic              arReady_r;
  logic              rValid_r;
  logic [31:0]       rData_r;
  logic [1:0]        rResp_r;
  logic [7:0]        awAddr_r;
  logic [31:0]       wData_r;
  logic [3:0]        wStrb_r;
  logic              hostMode_r;
  logic              trigger_r;
  logic [15:0]       request_r;
  logic [ADDR_W-1:0] busAddr;
  logic [UFRM_W-1:0] ufrmField;
  logic              doWrite;

  // true when the byte address names a register of this block
  function automatic logic isMapped(input logic [7:0] a);
    if (a == OFF_BUS_ADDR) begin
      return 1'b1;
    end else if (a == OFF_REQ_TYPE) begin
      return 1'b1;
    end else if (a == OFF_UFRM) begin
      return 1'b1;
    end else if (a == OFF_CTRL) begin
      return 1'b1;
    end else begin
      return 1'b0;
    end
  endfunction

  // merge the low two byte lanes of a write into a 16-bit field
  function automatic logic [15:0] laneMerge(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] s);
    logic [15:0] v;
    v = old;
    if (s[0]) begin
      v[7:0] = d[7:0];
    end
    if (s[1]) begin
      v[15:8] = d[15:8];
    end
    return v;
  endfunction

  uar_ufrm #(
    .W (UFRM_W)
  ) uFrm (
    .clk                    (clk),
    .arst_n                 (arst_n),
    .firstPortHs            (linkIn.firstPortHs),
    .secondPortHs           (linkIn.secondPortHs),
    .microframe             (linkIn.microframe),
    .microframeCountField_r (ufrmField)
  );

  uar_addr #(
    .W (ADDR_W)
  ) uAddr (
    .clk                  (clk),
    .arst_n               (arst_n),
    .hostMode             (hostMode_r),
    .setAddrDone          (linkIn.setAddrDone),
    .setAddrValue         (linkIn.setAddrValue),
    .busReset             (linkIn.busReset),
    .assignedBusAddress_r (busAddr)
  );

  // write path: address and data are taken in either order, then one response
  assign doWrite = !awReady_r && !wReady_r && !bValid_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      awReady_r <= 1'b1;
      awAddr_r  <= '0;
    end else if (s_axi_awvalid && awReady_r) begin
      awReady_r <= 1'b0;
      awAddr_r  <= s_axi_awaddr;
    end else if (bValid_r && s_axi_bready) begin
      awReady_r <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wReady_r <= 1'b1;
      wData_r  <= '0;
      wStrb_r  <= '0;
    end else if (s_axi_wvalid && wReady_r) begin
      wReady_r <= 1'b0;
      wData_r  <= s_axi_wdata;
      wStrb_r  <= s_axi_wstrb;
    end else if (bValid_r && s_axi_bready) begin
      wReady_r <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bValid_r <= 1'b0;
      bResp_r  <= RESP_OKAY;
    end else if (doWrite) begin
      bValid_r <= 1'b1;
      bResp_r  <= isMapped(awAddr_r) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bValid_r <= 1'b0;
    end
  end

  // mode and transmit trigger; a software set beats a same-cycle clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hostMode_r <= 1'b0;
      trigger_r  <= 1'b0;
    end else begin
      if (doWrite && awAddr_r == OFF_CTRL && wStrb_r[0]) begin
        hostMode_r <= wData_r[CTRL_HOST_BIT];
      end
      if (doWrite && awAddr_r == OFF_CTRL && wStrb_r[0] && wData_r[CTRL_TRIG_BIT] && hostMode_r) begin
        trigger_r <= 1'b1;
      end else if (linkIn.txDone || !hostMode_r) begin
        trigger_r <= 1'b0;
      end
    end
  end

  // setup request: captured in peripheral mode, written by software in host mode
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      request_r <= REQ_RST;
    end else if (!hostMode_r) begin
      if (linkIn.setupValid) begin
        request_r <= linkIn.setupReq;
      end
    end else if (doWrite && awAddr_r == OFF_REQ_TYPE) begin
      request_r <= laneMerge(request_r, wData_r, wStrb_r);
    end
  end

  // read path: one read at a time, data one cycle after the address
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      arReady_r <= 1'b1;
      rValid_r  <= 1'b0;
      rData_r   <= '0;
      rResp_r   <= RESP_OKAY;
    end else if (s_axi_arvalid && arReady_r) begin
      arReady_r <= 1'b0;
      rValid_r  <= 1'b1;
      rResp_r   <= isMapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      if (s_axi_araddr == OFF_BUS_ADDR) begin
        rData_r <= {{(32 - ADDR_W){1'b0}}, busAddr};
      end else if (s_axi_araddr == OFF_REQ_TYPE) begin
        rData_r <= {16'h0000, request_r};
      end else if (s_axi_araddr == OFF_UFRM) begin
        rData_r <= {{(32 - UFRM_W){1'b0}}, ufrmField};
      end else if (s_axi_araddr == OFF_CTRL) begin
        rData_r <= {30'h0, trigger_r, hostMode_r};
      end else begin
        rData_r <= '0;
      end
    end else if (rValid_r && s_axi_rready) begin
      arReady_r <= 1'b1;
      rValid_r  <= 1'b0;
    end
  end

  // link-facing state, all straight from flip-flops
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctlOut <= '0;
    end else begin
      ctlOut.hostMode             <= hostMode_r;
      ctlOut.setupTransmitTrigger <= trigger_r;
      ctlOut.assignedBusAddress   <= busAddr;
      ctlOut.setupRequestType     <= request_r;
    end
  end

  assign s_axi_awready = awReady_r;
  assign s_axi_wready  = wReady_r;
  assign s_axi_bvalid  = bValid_r;
  assign s_axi_bresp   = bResp_r;
  assign s_axi_arready = arReady_r;
  assign s_axi_rvalid  = rValid_r;
  assign s_axi_rdata   = rData_r;
  assign s_axi_rresp   = rResp_r;

  sequence s_host_req_write;
    hostMode_r && doWrite && awAddr_r == OFF_REQ_TYPE && wStrb_r[1:0] == 2'b11;
  endsequence

  sequence s_periph_setup;
    !hostMode_r && linkIn.setupValid;
  endsequence

  sequence s_rd_take;
    s_axi_arvalid && arReady_r;
  endsequence

  sequence s_b_take;
    bValid_r && s_axi_bready;
  endsequence

  sequence s_ctrl_write;
    doWrite && awAddr_r == OFF_CTRL && wStrb_r[0];
  endsequence

  a_req_capture: assert property (@(posedge clk) disable iff (!arst_n)
    s_periph_setup |=> request_r == $past(linkIn.setupReq) ##1 ctlOut.setupRequestType == $past(request_r))
    else $error("setup request not captured");
  a_req_hostwr: assert property (@(posedge clk) disable iff (!arst_n)
    s_host_req_write |=> request_r == $past(wData_r[15:0]))
    else $error("host request write lost");
  a_req_lock: assert property (@(posedge clk) disable iff (!arst_n)
    (!hostMode_r && !linkIn.setupValid) |=> $stable(request_r))
    else $error("request changed in peripheral mode without setup");
  a_req_layout: assert property (@(posedge clk) disable iff (!arst_n)
    (s_axi_arvalid && arReady_r && s_axi_araddr == OFF_REQ_TYPE)
      |=> s_axi_rdata[15:8] == $past(request_r[15:8]) && s_axi_rdata[7:0] == $past(request_r[7:0]))
    else $error("request type bytes misplaced");
  a_addr_upper: assert property (@(posedge clk) disable iff (!arst_n)
    (s_axi_arvalid && arReady_r && s_axi_araddr == OFF_BUS_ADDR) |=> s_axi_rdata[31:ADDR_W] == '0)
    else $error("address upper bits not zero");
  a_ufrm_read: assert property (@(posedge clk) disable iff (!arst_n)
    (!linkIn.firstPortHs && !linkIn.secondPortHs) ##1 (s_axi_arvalid && arReady_r && s_axi_araddr == OFF_UFRM)
      |=> s_axi_rdata == '0)
    else $error("microframe read not zero");
  a_wr_resp: assert property (@(posedge clk) disable iff (!arst_n)
    doWrite |=> bValid_r ##0 (bResp_r == (isMapped($past(awAddr_r)) ? RESP_OKAY : RESP_SLVERR)))
    else $error("write response wrong");
  a_trig_hold: assert property (@(posedge clk) disable iff (!arst_n)
    (trigger_r && hostMode_r && !linkIn.txDone) |=> trigger_r)
    else $error("trigger dropped without completion");

  // bus handshake and link-facing state
  a_aw_hold: assert property (@(posedge clk) disable iff (!arst_n)
    (!awReady_r && !(bValid_r && s_axi_bready)) |=> !awReady_r)
    else $error("write address reopened before response");
  a_w_hold: assert property (@(posedge clk) disable iff (!arst_n)
    (!wReady_r && !(bValid_r && s_axi_bready)) |=> !wReady_r)
    else $error("write data reopened before response");
  a_b_reopen: assert property (@(posedge clk) disable iff (!arst_n)
    s_b_take |=> awReady_r && wReady_r && !bValid_r)
    else $error("write channels not reopened after response");
  a_b_stand: assert property (@(posedge clk) disable iff (!arst_n)
    (bValid_r && !s_axi_bready) |=> bValid_r && $stable(bResp_r))
    else $error("write response not held");
  a_rd_answer: assert property (@(posedge clk) disable iff (!arst_n)
    s_rd_take |=> rValid_r && !arReady_r)
    else $error("read not answered next cycle");
  a_r_stand: assert property (@(posedge clk) disable iff (!arst_n)
    (rValid_r && !s_axi_rready) |=> rValid_r && $stable(s_axi_rdata) && $stable(rResp_r))
    else $error("read data not held");
  a_r_done: assert property (@(posedge clk) disable iff (!arst_n)
    (rValid_r && s_axi_rready) |=> !rValid_r && arReady_r)
    else $error("read channel not reopened");
  a_bad_read: assert property (@(posedge clk) disable iff (!arst_n)
    s_rd_take ##0 !isMapped(s_axi_araddr) |=> s_axi_rdata == '0 && s_axi_rresp == RESP_SLVERR)
    else $error("unmapped read not refused");
  a_mode_write: assert property (@(posedge clk) disable iff (!arst_n)
    s_ctrl_write |=> hostMode_r == $past(wData_r[CTRL_HOST_BIT]))
    else $error("mode bit not written");
  a_trig_set: assert property (@(posedge clk) disable iff (!arst_n)
    s_ctrl_write ##0 (hostMode_r && wData_r[CTRL_TRIG_BIT]) |=> trigger_r)
    else $error("trigger not set");
  a_trig_periph: assert property (@(posedge clk) disable iff (!arst_n)
    !hostMode_r |=> !trigger_r)
    else $error("trigger set in peripheral mode");
  a_trig_clear: assert property (@(posedge clk) disable iff (!arst_n)
    (linkIn.txDone && !(doWrite && awAddr_r == OFF_CTRL)) |=> !trigger_r)
    else $error("trigger not cleared on completion");
  a_req_ignored: assert property (@(posedge clk) disable iff (!arst_n)
    (!hostMode_r && !linkIn.setupValid && doWrite && awAddr_r == OFF_REQ_TYPE) |=> $stable(request_r))
    else $error("request written in peripheral mode");
  a_ctl_mode: assert property (@(posedge clk) disable iff (!arst_n)
    1'b1 |=> ctlOut.hostMode == $past(hostMode_r) && ctlOut.setupTransmitTrigger == $past(trigger_r))
    else $error("link mode or trigger not following");
  a_ctl_addr: assert property (@(posedge clk) disable iff (!arst_n)
    1'b1 |=> ctlOut.assignedBusAddress == $past(busAddr))
    else $error("link address not following");
endmodule

/* test/uar_link_model.sv */
// behavioural usb link logic that feeds events and levels to the register block
`timescale 1ns/1ps
module uar_link_model
  import uar_pkg::*;
(
  // clock and reset
  input  wire logic     clk,
  input  wire logic     arst_n,
  // register block side
  input  wire uar_ctl_t ctl,
  output uar_link_t     link
);
  int txDelay = 3;
  int txCnt   = 0;

  initial link = '0;

  // port speed and microframe levels, changed just after an edge
  task automatic levels(input logic hs0, input logic hs1, input logic [UFRM_W-1:0] mf);
    @(posedge clk);
    link.firstPortHs  <= hs0;
    link.secondPortHs <= hs1;
    link.microframe   <= mf;
  endtask

  // one-cycle set-address completion and/or bus reset; value bus scrambled afterwards
  task automatic addrEvent(input logic done, input logic rst, input logic [ADDR_W-1:0] v);
    @(posedge clk);
    link.setAddrDone  <= done;
    link.busReset     <= rst;
    link.setAddrValue <= v;
    @(posedge clk);
    link.setAddrDone  <= 1'b0;
    link.busReset     <= 1'b0;
    link.setAddrValue <= ~v;
  endtask

  // received setup stage, {request, request type} as on the wire
  task automatic setupEvent(input logic [15:0] req);
    @(posedge clk);
    link.setupValid <= 1'b1;
    link.setupReq   <= req;
    @(posedge clk);
    link.setupValid <= 1'b0;
    link.setupReq   <= ~req;
  endtask

  // finishes a host setup transmission txDelay+1 cycles after the trigger shows
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      txCnt       <= 0;
      link.txDone <= 1'b0;
    end else begin
      link.txDone <= 1'b0;
      if (ctl.hostMode && ctl.setupTransmitTrigger && !link.txDone) begin
        txCnt <= txCnt + 1;
        if (txCnt >= txDelay) begin
          link.txDone <= 1'b1;
          txCnt       <= 0;
        end
      end else begin
        txCnt <= 0;
      end
    end
  end
endmodule

/* test/usb_addr_request_regs_tb.sv */
// self-checking bench for the usb address and setup request registers
`timescale 1ns/1ps
module usb_addr_request_regs_tb
  import uar_pkg::*;
;
  localparam logic [7:0] OFF_BAD = 8'h60;
  logic        clk = 1'b0;
  logic        arstN = 1'b0;
  logic        awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
  logic [7:0]  awAddr = 8'h00, arAddr = 8'h00;
  logic [31:0] wData = 32'h0;
  logic [3:0]  wStrb = 4'h0;
  logic        awReady, wReady, bValid, arReady, rValid;
  logic [1:0]  bResp, rResp;
  logic [31:0] rData;
  uar_link_t   linkBus;
  uar_ctl_t    ctl;
  int          mismatches = 0;
  int          totalChecks = 0;

  always #2.5 clk = ~clk;

  uar_regs uut (.clk(clk), .arst_n(arstN), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_awaddr(awAddr), .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_wdata(wData),
    .s_axi_wstrb(wStrb), .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_bresp(bResp),
    .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_araddr(arAddr), .s_axi_rvalid(rValid),
    .s_axi_rready(rReady), .s_axi_rdata(rData), .s_axi_rresp(rResp), .linkIn(linkBus), .ctlOut(ctl));
  uar_link_model farEnd (.clk(clk), .arst_n(arstN), .ctl(ctl), .link(linkBus));

  task automatic final_report();
    $display("checks %0d mismatches %0d", totalChecks, mismatches);
    if (mismatches == 0 && totalChecks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic timedOut(input string nm);
    mismatches++;
    $display("mismatch %s expected answer seen none", nm);
    final_report();
  endtask

  task automatic axWrite(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                         output logic [1:0] r);
    int n;
    bit got;
    n = 0;
    got = 0;
    @(posedge clk);
    awValid <= 1'b1;
    awAddr  <= a;
    wValid  <= 1'b1;
    wData   <= d;
    wStrb   <= s;
    bReady  <= 1'b1;
    while (!got && n < 100) begin
      @(posedge clk);
      n++;
      if (awValid && awReady) awValid <= 1'b0;
      if (wValid && wReady) wValid <= 1'b0;
      if (bValid) begin
        bReady <= 1'b0;
        r = bResp;
        got = 1;
      end
    end
    if (!got) timedOut("write response");
  endtask

  task automatic axRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    bit got;
    n = 0;
    got = 0;
    @(posedge clk);
    arValid <= 1'b1;
    arAddr  <= a;
    rReady  <= 1'b1;
    while (!got && n < 100) begin
      @(posedge clk);
      n++;
      if (arValid && arReady) arValid <= 1'b0;
      if (rValid) begin
        rReady <= 1'b0;
        d = rData;
        r = rResp;
        got = 1;
      end
    end
    if (!got) timedOut("read data");
  endtask

  task automatic t_reset();
    logic [31:0] d;
    logic [1:0]  r;
    logic [7:0]  offs[3] = '{OFF_BUS_ADDR, OFF_REQ_TYPE, OFF_CTRL};
    for (int i = 0; i < 3; i++) begin
      axRead(offs[i], d, r);
      chk("reset value", d, 32'h0);
      chk("reset read resp", r, RESP_OKAY);
    end
    chk("reset ctl", ctl, '0);
  endtask

  task automatic t_ufrm();
    logic [31:0] d1, d2;
    logic [1:0]  r;
    logic [2:0]  mf;
    for (int i = 0; i < 4; i++) begin
      mf = 3'(i) + 3'h3;
      farEnd.levels(i[0], i[1], mf);
      axRead(OFF_UFRM, d1, r);
      axRead(OFF_UFRM, d2, r);
      chk("ufrm reread", d2, d1);
      chk("ufrm", d2, (i != 0) ? {29'h0, mf} : 32'h0);
    end
  endtask

  task automatic t_addr();
    logic [31:0] d;
    logic [1:0]  r;
    farEnd.addrEvent(1'b1, 1'b0, 7'h2a);
    farEnd.addrEvent(1'b0, 1'b0, 7'h11);
    axRead(OFF_BUS_ADDR, d, r);
    chk("addr set", d, 32'h2a);
    axWrite(OFF_BUS_ADDR, 32'hffffffff, 4'hf, r);
    chk("addr write resp", r, RESP_OKAY);
    axRead(OFF_BUS_ADDR, d, r);
    chk("addr read only", d, 32'h2a);
    farEnd.addrEvent(1'b1, 1'b1, 7'h33);
    axRead(OFF_BUS_ADDR, d, r);
    chk("addr bus reset", d, 32'h0);
    farEnd.addrEvent(1'b1, 1'b0, 7'h15);
    axRead(OFF_BUS_ADDR, d, r);
    chk("addr ctl", ctl.assignedBusAddress, 7'h15);
  endtask

  task automatic t_periph_req();
    logic [31:0] d;
    logic [1:0]  r;
    farEnd.setupEvent(16'h0680);
    axRead(OFF_REQ_TYPE, d, r);
    chk("req capture", d, 32'h0680);
    chk("req bytes", ctl.setupRequestType, {8'h06, 8'h80});
    axWrite(OFF_REQ_TYPE, 32'h1234, 4'h3, r);
    axWrite(OFF_CTRL, 32'h2, 4'h1, r);
    axRead(OFF_REQ_TYPE, d, r);
    chk("req locked", d, 32'h0680);
    axRead(OFF_CTRL, d, r);
    chk("no trigger", d, 32'h0);
  endtask

  task automatic t_host(input int delay);
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    farEnd.txDelay = delay;
    axWrite(OFF_CTRL, 32'h1, 4'h1, r);
    axWrite(OFF_REQ_TYPE, 32'h0509, 4'h3, r);
    axWrite(OFF_REQ_TYPE, 32'hffffffa1, 4'h1, r);
    farEnd.setupEvent(16'h0100);
    farEnd.addrEvent(1'b1, 1'b0, 7'h44);
    axRead(OFF_REQ_TYPE, d, r);
    chk("host req", d, 32'h05a1);
    axRead(OFF_BUS_ADDR, d, r);
    chk("host addr kept", d, 32'h15);
    axWrite(OFF_CTRL, 32'h3, 4'h1, r);
    @(posedge clk);
    chk("trigger set", ctl.setupTransmitTrigger, 1'b1);
    chk("ctl host", ctl.hostMode, 1'b1);
    n = 0;
    while (ctl.setupTransmitTrigger !== 1'b0 && n < 200) begin
      @(posedge clk);
      n++;
    end
    if (n >= 200) timedOut("trigger clear");
    axRead(OFF_CTRL, d, r);
    chk("trigger cleared", d, 32'h1);
    axWrite(OFF_CTRL, 32'h0, 4'h1, r);
  endtask

  task automatic t_unmapped();
    logic [31:0] d;
    logic [1:0]  r;
    axWrite(OFF_BAD, 32'h5a5a5a5a, 4'hf, r);
    chk("bad write resp", r, RESP_SLVERR);
    axRead(OFF_BAD, d, r);
    chk("bad read data", d, 32'h0);
    chk("bad read resp", r, RESP_SLVERR);
  endtask

  initial begin
    repeat (20) @(posedge clk);
    arstN <= 1'b1;
    t_reset();
    t_ufrm();
    t_addr();
    t_periph_req();
    t_host(3);
    t_host(20);
    t_unmapped();
    final_report();
  end
endmodule
